// [inc/dcl_pkg.sv]
`default_nettype none
package dcl_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CODE_W = 10;
    localparam int INT_W  = 2;

    // Register byte offsets
    localparam logic [7:0] OFS_PRIMARY   = 8'h00;
    localparam logic [7:0] OFS_SECONDARY = 8'h04;
    localparam logic [7:0] OFS_EVENT     = 8'h08;
    localparam logic [7:0] OFS_INT_MASK  = 8'h0c;
    localparam logic [7:0] OFS_INT_FLAG  = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;
    localparam logic [7:0] OFS_DATA      = 8'h18;
    localparam logic [7:0] OFS_BUFFER    = 8'h1c;

    // Field positions
    localparam int PRI_RESET_BIT   = 0;
    localparam int PRI_ENABLE_BIT  = 1;
    localparam int SEC_REFERENCE_SELECT_FIELD_LSB  = 0;
    localparam int REFERENCE_SELECT_FIELD_W        = 2;
    localparam int SEC_LEFTADJ_BIT = 2;
    localparam int EVT_START_BIT   = 0;
    localparam int EVT_INVERT_BIT  = 1;
    localparam int INT_DONE_BIT    = 0;
    localparam int INT_UNDERRUN_BIT = 1;
    localparam int STS_READY_BIT   = 0;
    localparam int STS_BUSY_BIT    = 1;
    localparam int LEFTADJ_LSB     = 6;

    // Reset values
    localparam logic [REFERENCE_SELECT_FIELD_W-1:0] REFERENCE_SELECT_FIELD_RST = 2'h0;
    localparam logic [CODE_W-1:0]   CODE_RST   = 10'h000;
    localparam logic [INT_W-1:0]    INT_RST    = 2'h0;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS  = 2858;
    localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_NS    = 2000;
    localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 6;

    typedef enum logic [1:0] {
        DCL_IDLE = 2'b00,
        DCL_LOAD = 2'b01,
        DCL_CONV = 2'b11
    } dcl_seq_state_type;

    function automatic logic dcl_hit(input logic [7:0] addr, input logic [7:0] ofs);
        dcl_hit = (addr == ofs);
    endfunction

endpackage
`default_nettype wire

// [hw/dcl_evt_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module dcl_evt_sync (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic level_in,
    output logic      rise_out,
    output logic      fall_out
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Only sync_q looks at meta_q
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= level_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise_out = sync_q & ~last_q;
    assign fall_out = ~sync_q & last_q;
endmodule
`default_nettype wire

// [hw/dcl_conv_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module dcl_conv_seq (
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    input  wire logic                       clear_in,
    input  wire logic                       start_in,
    input  wire logic [dcl_pkg::CODE_W-1:0] code_in,
    output logic      [dcl_pkg::CODE_W-1:0] code_out,
    output logic                            busy_out,
    output logic                            done_out
);
    import dcl_pkg::*;

    localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(CONV_CYCLES - 1);

    dcl_seq_state_type state_q;
    dcl_seq_state_type state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic              cnt_end;

    assign cnt_end = (cnt_q == LAST_CNT);

    // A new start restarts the settling time
    always_comb begin
        state_d = state_q;
        case (state_q)
            DCL_IDLE: state_d = start_in ? DCL_LOAD : DCL_IDLE;
            DCL_LOAD: state_d = DCL_CONV;
            DCL_CONV: begin
                if (start_in) begin
                    state_d = DCL_LOAD;
                end else if (cnt_end) begin
                    state_d = DCL_IDLE;
                end
            end
            default: state_d = DCL_IDLE;
        endcase
        if (clear_in) begin
            state_d = DCL_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q  <= DCL_IDLE;
            cnt_q    <= '0;
            code_out <= CODE_RST;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= (state_q == DCL_CONV) ? cnt_q + 1'b1 : '0;
            busy_out <= (state_d != DCL_IDLE);
            done_out <= (state_q == DCL_CONV) && (state_d == DCL_IDLE) && !clear_in;
            if (start_in && !clear_in) begin
                code_out <= code_in;
            end
        end
    end
endmodule
`default_nettype wire

// [hw/dcl_top.sv]
// What this block does
// - Guard marks block secure: non-secure writes dropped, reads zero, error raised.
// - Guard marks block non-secure: secure and non-secure accesses both accepted.
// - Writing the data register starts a new conversion.
// - An enabled incoming system event also starts a conversion.
// - Secondary control and event control writable only while enable is clear.
// - Writing one to the enable bit switches the converter on.
// - Writing zero to the enable bit switches the converter off.
// - Guard write-lock never blocks accesses from the external debugger.
// - One channel taking a ten-bit code per conversion.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dcl_top (
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    input  wire logic [dcl_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [dcl_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                       wr_in,
    input  wire logic                       rd_in,
    input  wire logic                       secure_access_in,
    input  wire logic                       debug_access_in,
    input  wire logic                       guard_secure_in,
    input  wire logic                       guard_wlock_in,
    input  wire logic                       event_in,
    output logic      [dcl_pkg::DATA_W-1:0] rdata_out,
    output logic                            access_err_out,
    output logic                            irq_out,
    output logic      [dcl_pkg::CODE_W-1:0] dac_code_out,
    output logic                            conv_busy_out,
    output logic      [dcl_pkg::REFERENCE_SELECT_FIELD_W-1:0] ref_select_out,
    output logic                            dac_enable_out,
    output logic                            dac_ready_out
);
    import dcl_pkg::*;

    localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP_CYCLES - 1);

    // Control and configuration state
    logic                enable_q;
    logic [REFERENCE_SELECT_FIELD_W-1:0] reference_select_field_q;
    logic                leftadj_q;
    logic                evt_start_q;
    logic                evt_invert_q;
    logic [INT_W-1:0]    mask_q;
    logic [INT_W-1:0]    flag_q;
    logic [INT_W-1:0]    flag_d;
    logic [CODE_W-1:0]   data_q;
    logic [CODE_W-1:0]   buf_q;
    logic [CNT_W-1:0]    startup_q;
    logic                ready_q;
    logic [DATA_W-1:0]   rdata_q;
    logic                err_q;
    logic                irq_q;

    // Access filtering
    logic access_ok;
    logic lock_block;
    logic wr_go;
    logic rd_go;
    logic err_d;

    // Address decode
    logic hit_pri;
    logic hit_sec;
    logic hit_evt;
    logic hit_mask;
    logic hit_flag;
    logic hit_sts;
    logic hit_data;
    logic hit_buf;
    logic wr_pri;
    logic wr_sec;
    logic wr_evt;
    logic wr_mask;
    logic wr_flag;
    logic wr_data;
    logic wr_buf;
    logic sw_reset;

    // Conversion control
    logic              evt_rise;
    logic              evt_fall;
    logic              evt_fire;
    logic              data_start;
    logic              evt_start;
    logic              seq_start;
    logic [CODE_W-1:0] wr_code;
    logic [CODE_W-1:0] seq_code;
    logic [CODE_W-1:0] seq_code_q;
    logic              seq_busy;
    logic              seq_done;
    logic              underrun;
    logic [INT_W-1:0]  flag_set;
    logic [DATA_W-1:0] rd_mux;

    // Secure block refuses non-secure origin; non-secure block takes all
    assign access_ok  = !guard_secure_in || secure_access_in;
    // Debugger writes bypass the guard's write-lock
    assign lock_block = guard_wlock_in && !debug_access_in;
    assign wr_go      = wr_in && access_ok && !lock_block;
    // Reads are never write-locked
    assign rd_go      = rd_in && access_ok;
    assign err_d      = ((wr_in || rd_in) && !access_ok)
                        || (wr_in && access_ok && lock_block);

    assign hit_pri  = dcl_hit(addr_in, OFS_PRIMARY);
    assign hit_sec  = dcl_hit(addr_in, OFS_SECONDARY);
    assign hit_evt  = dcl_hit(addr_in, OFS_EVENT);
    assign hit_mask = dcl_hit(addr_in, OFS_INT_MASK);
    assign hit_flag = dcl_hit(addr_in, OFS_INT_FLAG);
    assign hit_sts  = dcl_hit(addr_in, OFS_STATUS);
    assign hit_data = dcl_hit(addr_in, OFS_DATA);
    assign hit_buf  = dcl_hit(addr_in, OFS_BUFFER);

    assign wr_pri   = wr_go && hit_pri;
    // Enable-protected registers drop writes while running
    assign wr_sec   = wr_go && hit_sec && !enable_q;
    assign wr_evt   = wr_go && hit_evt && !enable_q;
    assign wr_mask  = wr_go && hit_mask;
    assign wr_flag  = wr_go && hit_flag;
    assign wr_data  = wr_go && hit_data;
    assign wr_buf   = wr_go && hit_buf;
    assign sw_reset = wr_pri && wdata_in[PRI_RESET_BIT];

    // Left-adjusted mode takes the code from the upper bits
    assign wr_code = leftadj_q ? wdata_in[LEFTADJ_LSB +: CODE_W]
                               : wdata_in[CODE_W-1:0];

    dcl_evt_sync u_evt_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .level_in (event_in),
        .rise_out (evt_rise),
        .fall_out (evt_fall)
    );

    // Polarity bit picks which event edge starts
    assign evt_fire   = evt_invert_q ? evt_fall : evt_rise;
    // Conversions only once the analog side has settled after enable
    assign data_start = wr_data && enable_q && ready_q;
    assign evt_start  = evt_fire && evt_start_q && enable_q && ready_q;
    // Event during a running conversion is dropped, and flagged unless a data write starts in the same cycle
    assign underrun   = evt_start && seq_busy && !data_start;
    assign seq_start  = data_start || (evt_start && !seq_busy);
    // Event path converts the buffered code, data path the fresh write
    assign seq_code   = data_start ? wr_code : buf_q;

    dcl_conv_seq u_conv_seq (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .clear_in (!enable_q || sw_reset),
        .start_in (seq_start),
        .code_in  (seq_code),
        .code_out (seq_code_q),
        .busy_out (seq_busy),
        .done_out (seq_done)
    );

    // Flag positions come from the package, not from bit order
    always_comb begin
        flag_set                   = INT_RST;
        flag_set[INT_DONE_BIT]     = seq_done;
        flag_set[INT_UNDERRUN_BIT] = underrun;
    end
    // Hardware set beats a simultaneous write-one clear
    assign flag_d   = (flag_q & ~(wr_flag ? wdata_in[INT_W-1:0] : INT_RST)) | flag_set;

    always_comb begin
        rd_mux = '0;
        if (hit_pri) begin
            rd_mux[PRI_ENABLE_BIT] = enable_q;
        end else if (hit_sec) begin
            rd_mux[SEC_REFERENCE_SELECT_FIELD_LSB +: REFERENCE_SELECT_FIELD_W] = reference_select_field_q;
            rd_mux[SEC_LEFTADJ_BIT] = leftadj_q;
        end else if (hit_evt) begin
            rd_mux[EVT_START_BIT]  = evt_start_q;
            rd_mux[EVT_INVERT_BIT] = evt_invert_q;
        end else if (hit_mask) begin
            rd_mux[INT_W-1:0] = mask_q;
        end else if (hit_flag) begin
            rd_mux[INT_W-1:0] = flag_q;
        end else if (hit_sts) begin
            rd_mux[STS_READY_BIT] = ready_q;
            rd_mux[STS_BUSY_BIT]  = seq_busy;
        end else if (hit_data) begin
            rd_mux[CODE_W-1:0] = data_q;
        end else if (hit_buf) begin
            rd_mux[CODE_W-1:0] = buf_q;
        end
    end

    // Enable bit follows the written value
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_q <= 1'b0;
        end else if (sw_reset) begin
            enable_q <= 1'b0;
        end else if (wr_pri) begin
            enable_q <= wdata_in[PRI_ENABLE_BIT];
        end
    end

    // Reference write is dropped while enable is set; software sets it first
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reference_select_field_q  <= REFERENCE_SELECT_FIELD_RST;
            leftadj_q <= 1'b0;
        end else if (sw_reset) begin
            reference_select_field_q  <= REFERENCE_SELECT_FIELD_RST;
            leftadj_q <= 1'b0;
        end else if (wr_sec) begin
            reference_select_field_q  <= wdata_in[SEC_REFERENCE_SELECT_FIELD_LSB +: REFERENCE_SELECT_FIELD_W];
            leftadj_q <= wdata_in[SEC_LEFTADJ_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            evt_start_q  <= 1'b0;
            evt_invert_q <= 1'b0;
        end else if (sw_reset) begin
            evt_start_q  <= 1'b0;
            evt_invert_q <= 1'b0;
        end else if (wr_evt) begin
            evt_start_q  <= wdata_in[EVT_START_BIT];
            evt_invert_q <= wdata_in[EVT_INVERT_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_q <= INT_RST;
            flag_q <= INT_RST;
        end else if (sw_reset) begin
            mask_q <= INT_RST;
            flag_q <= INT_RST;
        end else begin
            flag_q <= flag_d;
            if (wr_mask) begin
                mask_q <= wdata_in[INT_W-1:0];
            end
        end
    end

    // Data register keeps what was written, even while disabled
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_q <= CODE_RST;
            buf_q  <= CODE_RST;
        end else if (sw_reset) begin
            data_q <= CODE_RST;
            buf_q  <= CODE_RST;
        end else begin
            if (wr_data) begin
                data_q <= wr_code;
            end else if (evt_start && !seq_busy) begin
                data_q <= buf_q;
            end
            if (wr_buf) begin
                buf_q <= wr_code;
            end
        end
    end

    // Start-up delay models analog settling after enable
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            startup_q <= '0;
            ready_q   <= 1'b0;
        end else if (!enable_q || sw_reset) begin
            startup_q <= '0;
            ready_q   <= 1'b0;
        end else if (!ready_q) begin
            startup_q <= startup_q + 1'b1;
            ready_q   <= (startup_q == STARTUP_LAST);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= '0;
            err_q   <= 1'b0;
            irq_q   <= 1'b0;
        end else begin
            rdata_q <= rd_go ? rd_mux : '0;
            err_q   <= err_d;
            // Reset write must not leave a stray request behind
            irq_q   <= !sw_reset && |(flag_d & mask_q);
        end
    end

    assign rdata_out      = rdata_q;
    assign access_err_out = err_q;
    assign irq_out        = irq_q;
    assign dac_code_out   = seq_code_q;
    assign conv_busy_out  = seq_busy;
    assign ref_select_out = reference_select_field_q;
    assign dac_enable_out = enable_q;
    assign dac_ready_out  = ready_q;
endmodule
`default_nettype wire

// [test/dcl_top_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module dcl_top_chk (
    input wire logic                         clk_in,
    input wire logic                         rst_n_in,
    input wire logic [dcl_pkg::ADDR_W-1:0]   addr_in,
    input wire logic [dcl_pkg::DATA_W-1:0]   wdata_in,
    input wire logic                         wr_in,
    input wire logic                         rd_in,
    input wire logic                         secure_access_in,
    input wire logic                         debug_access_in,
    input wire logic                         guard_secure_in,
    input wire logic                         guard_wlock_in,
    input wire logic                         event_in,
    input wire logic [dcl_pkg::DATA_W-1:0]   rdata_out,
    input wire logic                         access_err_out,
    input wire logic                         irq_out,
    input wire logic [dcl_pkg::CODE_W-1:0]   dac_code_out,
    input wire logic                         conv_busy_out,
    input wire logic [dcl_pkg::REFERENCE_SELECT_FIELD_W-1:0] ref_select_out,
    input wire logic                         dac_enable_out,
    input wire logic                         dac_ready_out
);
    import dcl_pkg::*;
    wire bad_sec = guard_secure_in && !secure_access_in;
    wire ok_wr   = wr_in && !bad_sec && !(guard_wlock_in && !debug_access_in);
    wire pri_wr  = ok_wr && addr_in == OFS_PRIMARY && !wdata_in[PRI_RESET_BIT];
    // Left-adjust bit has no port, so it is shadowed from the writes
    logic adj_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            adj_q <= 1'b0;
        end else if (ok_wr && addr_in == OFS_PRIMARY && wdata_in[PRI_RESET_BIT]) begin
            adj_q <= 1'b0;
        end else if (ok_wr && addr_in == OFS_SECONDARY && !dac_enable_out) begin
            adj_q <= wdata_in[SEC_LEFTADJ_BIT];
        end
    end
    wire [CODE_W-1:0] exp_code = adj_q ? wdata_in[LEFTADJ_LSB +: CODE_W]
                                       : wdata_in[CODE_W-1:0];
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Start is only honoured once start-up has finished
    sequence data_start;
        ok_wr && addr_in == OFS_DATA && dac_enable_out && dac_ready_out;
    endsequence
    sequence conv_running;
        conv_busy_out && dac_code_out == $past(exp_code);
    endsequence
    sec_read_zero_a: assert property (rd_in && bad_sec |=> rdata_out == '0)
        else $error("secure guard read not zero");
    sec_error_a: assert property ((wr_in || rd_in) && bad_sec |=> access_err_out)
        else $error("secure guard gave no error");
    open_access_a: assert property ((wr_in || rd_in) && !bad_sec && !guard_wlock_in
        |=> !access_err_out)
        else $error("granted access raised error");
    debug_pass_a: assert property ((wr_in || rd_in) && !bad_sec && debug_access_in
        |=> !access_err_out)
        else $error("debugger access raised error");
    data_conv_a: assert property (data_start |=> conv_running)
        else $error("data write started no conversion");
    enable_on_a: assert property (pri_wr && wdata_in[PRI_ENABLE_BIT] |=> dac_enable_out)
        else $error("enable write ignored");
    enable_off_a: assert property (pri_wr && !wdata_in[PRI_ENABLE_BIT] |=> !dac_enable_out)
        else $error("disable write ignored");
    ref_locked_a: assert property (wr_in && addr_in == OFS_SECONDARY && dac_enable_out
        |=> $stable(ref_select_out))
        else $error("locked reference changed");
    ref_open_a: assert property (ok_wr && addr_in == OFS_SECONDARY && !dac_enable_out
        |=> ref_select_out == $past(wdata_in[REFERENCE_SELECT_FIELD_W-1:0]))
        else $error("reference write lost");
endmodule
bind dcl_top dcl_top_chk i_chk (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .secure_access_in, .debug_access_in, .guard_secure_in, .guard_wlock_in, .event_in,
    .rdata_out, .access_err_out, .irq_out, .dac_code_out, .conv_busy_out, .ref_select_out,
    .dac_enable_out, .dac_ready_out);
`default_nettype wire

// [test/test_dcl_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_dcl_top;
    import dcl_pkg::*;
    logic                clk_in, rst_n_in, wr_in, rd_in, event_in;
    logic                secure_access_in, debug_access_in, guard_secure_in, guard_wlock_in;
    logic [ADDR_W-1:0]   addr_in;
    logic [DATA_W-1:0]   wdata_in, rdata_out, seen;
    logic                access_err_out, irq_out, conv_busy_out, dac_enable_out;
    logic                dac_ready_out, err_seen;
    logic [CODE_W-1:0]   dac_code_out;
    logic [REFERENCE_SELECT_FIELD_W-1:0] ref_select_out;
    int                  mismatches = 0;
    int                  n_checks = 0;

    dcl_top i_dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .secure_access_in, .debug_access_in, .guard_secure_in, .guard_wlock_in, .event_in,
        .rdata_out, .access_err_out, .irq_out, .dac_code_out, .conv_busy_out,
        .ref_select_out, .dac_enable_out, .dac_ready_out);

    task automatic finish_test;
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Answer and error stand only in the cycle after the strobe
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= w;
        rd_in <= !w;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1;
        seen = rdata_out;
        err_seen = access_err_out;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        access(1'b1, a, d);
        chk("write error", {31'h0, e}, {31'h0, err_seen});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        access(1'b0, a, 32'h0);
        chk("read data", d, seen);
        chk("read error", {31'h0, e}, {31'h0, err_seen});
    endtask

    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // About 320 cycles of traffic; over fifteen times that is a hang
    initial begin
        #250000;
        mismatches++;
        finish_test();
    end

    initial begin
        {rst_n_in, wr_in, rd_in, event_in, secure_access_in, debug_access_in} = '0;
        {guard_secure_in, guard_wlock_in} = '0;
        addr_in = '0;
        wdata_in = '0;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(OFS_PRIMARY, 32'h0, 1'b0);
        wr(OFS_SECONDARY, 32'h2, 1'b0);
        chk("reference", 32'h2, {30'h0, ref_select_out});
        guard_secure_in <= 1'b1;
        wr(OFS_SECONDARY, 32'h3, 1'b1);
        rd(OFS_SECONDARY, 32'h0, 1'b1);
        secure_access_in <= 1'b1;
        rd(OFS_SECONDARY, 32'h2, 1'b0);
        wr(OFS_SECONDARY, 32'h3, 1'b0);
        wr(8'h40, 32'h5, 1'b0);
        rd(8'h40, 32'h0, 1'b0);
        wr(OFS_PRIMARY, 32'h2, 1'b0);
        chk("enable", 32'h1, {31'h0, dac_enable_out});
        chk("ready", 32'h0, {31'h0, dac_ready_out});
        for (int i = 0; i < 100 && dac_ready_out !== 1'b1; i++) tick();
        chk("ready", 32'h1, {31'h0, dac_ready_out});
        rd(OFS_STATUS, 32'h1, 1'b0);
        wr(OFS_SECONDARY, 32'h1, 1'b0);
        rd(OFS_SECONDARY, 32'h3, 1'b0);
        wr(OFS_EVENT, 32'h1, 1'b0);
        rd(OFS_EVENT, 32'h0, 1'b0);
        guard_wlock_in <= 1'b1;
        wr(OFS_DATA, 32'h3ff, 1'b1);
        debug_access_in <= 1'b1;
        wr(OFS_DATA, 32'hffff_fd55, 1'b0);
        chk("code", 32'h155, {22'h0, dac_code_out});
        chk("busy", 32'h1, {31'h0, conv_busy_out});
        rd(OFS_DATA, 32'h155, 1'b0);
        guard_wlock_in <= 1'b0;
        debug_access_in <= 1'b0;
        wr(OFS_INT_MASK, 32'h1, 1'b0);
        for (int i = 0; i < 100 && conv_busy_out !== 1'b0; i++) tick();
        rd(OFS_INT_FLAG, 32'h1, 1'b0);
        chk("irq", 32'h1, {31'h0, irq_out});
        wr(OFS_INT_FLAG, 32'h1, 1'b0);
        tick();
        chk("irq", 32'h0, {31'h0, irq_out});
        wr(OFS_PRIMARY, 32'h0, 1'b0);
        chk("enable", 32'h0, {31'h0, dac_enable_out});
        wr(OFS_EVENT, 32'h1, 1'b0);
        rd(OFS_EVENT, 32'h1, 1'b0);
        wr(OFS_BUFFER, 32'h0aa, 1'b0);
        wr(OFS_PRIMARY, 32'h2, 1'b0);
        for (int i = 0; i < 100 && dac_ready_out !== 1'b1; i++) tick();
        event_in <= 1'b1;
        for (int i = 0; i < 12 && conv_busy_out !== 1'b1; i++) tick();
        chk("event code", 32'h0aa, {22'h0, dac_code_out});
        rd(OFS_DATA, 32'h0aa, 1'b0);
        event_in <= 1'b0;
        repeat (3) tick();
        event_in <= 1'b1;
        repeat (4) tick();
        rd(OFS_INT_FLAG, 32'h2, 1'b0);
        wr(OFS_PRIMARY, 32'h1, 1'b0);
        rd(OFS_SECONDARY, 32'h0, 1'b0);
        rd(OFS_INT_FLAG, 32'h0, 1'b0);
        wr(OFS_SECONDARY, 32'h4, 1'b0);
        wr(OFS_PRIMARY, 32'h2, 1'b0);
        for (int i = 0; i < 100 && dac_ready_out !== 1'b1; i++) tick();
        wr(OFS_DATA, 32'hffc0, 1'b0);
        chk("code", 32'h3ff, {22'h0, dac_code_out});
        wr(OFS_PRIMARY, 32'h0, 1'b0);
        wr(OFS_EVENT, 32'h3, 1'b0);
        wr(OFS_BUFFER, 32'h3c00, 1'b0);
        wr(OFS_PRIMARY, 32'h2, 1'b0);
        for (int i = 0; i < 100 && dac_ready_out !== 1'b1; i++) tick();
        event_in <= 1'b0;
        for (int i = 0; i < 12 && conv_busy_out !== 1'b1; i++) tick();
        chk("event code", 32'h0f0, {22'h0, dac_code_out});
        finish_test();
    end
endmodule
`default_nettype wire
